//--- hdl/awd_pkg.sv
// constants, carrier types and register map of the converter window detector
package awd_pkg;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 8;
  localparam int unsigned WW = 16;
  localparam logic [AW-1:0] ADDR_CTRL       = 8'hE8;
  localparam logic [AW-1:0] ADDR_UPPER_HIGH = 8'hC3;
  localparam logic [AW-1:0] ADDR_UPPER_LOW  = 8'hC2;
  localparam logic [AW-1:0] ADDR_LOWER_HIGH = 8'hC5;
  localparam logic [AW-1:0] ADDR_LOWER_LOW  = 8'hC4;
  localparam logic [AW-1:0] ADDR_RES_HIGH   = 8'hBE;
  localparam logic [AW-1:0] ADDR_RES_LOW    = 8'hBD;
  localparam int unsigned   CTRL_FLAG_BIT   = 3;
  localparam logic [DW-1:0] CTRL_RESET      = 8'h00;
  localparam logic [WW-1:0] UPPER_RESET     = 16'h0000;
  localparam logic [WW-1:0] LOWER_RESET     = 16'h0000;
  localparam logic [WW-1:0] RESULT_RESET    = 16'h0000;
  localparam int unsigned   CONV_MIN_CLKS   = 10;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          we;
    logic          re;
  } awd_sfr_req_t;

  typedef struct packed {
    logic          done;
    logic          diff;
    logic [WW-1:0] word;
  } awd_result_t;
endpackage

//--- hdl/awd_top.sv
// window comparator on the converter result with its special-function registers
`timescale 1ns/100ps
module awd_top
  import awd_pkg::*;
(
  input  wire logic          CLOCK_I,
  input  wire logic          RSTN_I,
  input  wire awd_sfr_req_t  SFR_REQ_I,
  input  wire awd_result_t   RESULT_I,
  output logic [DW-1:0]      SFR_RDATA_O,
  output logic               WIN_FLAG_O
);

  logic [DW-1:0] ctrl_q;
  logic [WW-1:0] upper_q;
  logic [WW-1:0] lower_q;
  logic [WW-1:0] result_q;
  logic          flag_q;
  logic          flag_d;
  logic          match;
  logic          clr_wr;

  // true when a is greater than b, signed or unsigned
  function automatic logic gt_cmp(input logic [WW-1:0] a, input logic [WW-1:0] b,
                                  input logic sgn);
    if (sgn) begin
      gt_cmp = $signed(a) > $signed(b);
    end else begin
      gt_cmp = a > b;
    end
  endfunction

  always_comb begin
    logic above;
    logic below;
    logic in_win;
    above  = gt_cmp(RESULT_I.word, upper_q, RESULT_I.diff);
    below  = gt_cmp(lower_q, RESULT_I.word, RESULT_I.diff);
    in_win = gt_cmp(lower_q, upper_q, RESULT_I.diff);
    if (in_win) begin
      match = above && below;
    end else begin
      // equal limits fall here, so every code except the limit itself matches
      match = above || below;
    end
  end

  assign clr_wr = SFR_REQ_I.we && (SFR_REQ_I.addr == ADDR_CTRL)
                  && !SFR_REQ_I.wdata[CTRL_FLAG_BIT];

  // a result landing in the clearing cycle wins, so no match is lost
  always_comb begin
    flag_d = flag_q;
    if (clr_wr) begin
      flag_d = 1'h0;
    end
    if (RESULT_I.done && match) begin
      flag_d = 1'h1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      flag_q <= 1'h0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // remaining control bits belong to the converter and are only stored here
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      ctrl_q <= CTRL_RESET;
    end else if (SFR_REQ_I.we && SFR_REQ_I.addr == ADDR_CTRL) begin
      ctrl_q <= SFR_REQ_I.wdata;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      upper_q <= UPPER_RESET;
      lower_q <= LOWER_RESET;
    end else if (SFR_REQ_I.we) begin
      unique case (SFR_REQ_I.addr)
        ADDR_UPPER_HIGH: upper_q[15:8] <= SFR_REQ_I.wdata;
        ADDR_UPPER_LOW:  upper_q[7:0]  <= SFR_REQ_I.wdata;
        ADDR_LOWER_HIGH: lower_q[15:8] <= SFR_REQ_I.wdata;
        ADDR_LOWER_LOW:  lower_q[7:0]  <= SFR_REQ_I.wdata;
        default: ;
      endcase
    end
  end

  // the result word is captured only when the converter reports completion
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      result_q <= RESULT_RESET;
    end else if (RESULT_I.done) begin
      result_q <= RESULT_I.word;
    end
  end

  // read data is registered, one cycle behind the read strobe; unmapped reads give zero
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      SFR_RDATA_O <= '0;
    end else if (SFR_REQ_I.re) begin
      unique case (SFR_REQ_I.addr)
        ADDR_CTRL: begin
          SFR_RDATA_O                <= ctrl_q;
          SFR_RDATA_O[CTRL_FLAG_BIT] <= flag_q;
        end
        ADDR_UPPER_HIGH: SFR_RDATA_O <= upper_q[15:8];
        ADDR_UPPER_LOW:  SFR_RDATA_O <= upper_q[7:0];
        ADDR_LOWER_HIGH: SFR_RDATA_O <= lower_q[15:8];
        ADDR_LOWER_LOW:  SFR_RDATA_O <= lower_q[7:0];
        ADDR_RES_HIGH:   SFR_RDATA_O <= result_q[15:8];
        ADDR_RES_LOW:    SFR_RDATA_O <= result_q[7:0];
        default:         SFR_RDATA_O <= '0;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      WIN_FLAG_O <= 1'h0;
    end else begin
      WIN_FLAG_O <= flag_d;
    end
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);

  sequence s_clear;
    SFR_REQ_I.we && SFR_REQ_I.addr == ADDR_CTRL && !SFR_REQ_I.wdata[CTRL_FLAG_BIT];
  endsequence
  sequence s_quiet;
    !RESULT_I.done && !(SFR_REQ_I.we && SFR_REQ_I.addr == ADDR_CTRL);
  endsequence

  property p_inside;
    RESULT_I.done && !RESULT_I.diff && upper_q < lower_q
      && RESULT_I.word > upper_q && RESULT_I.word < lower_q |=> flag_q && WIN_FLAG_O;
  endproperty
  a_inside: assert property (p_inside) else $error("inside result did not set flag");

  property p_inside_miss;
    RESULT_I.done && !RESULT_I.diff && !flag_q && !SFR_REQ_I.we
      && upper_q == 16'h0040 && lower_q == 16'h0080 && RESULT_I.word == 16'h0040 |=> !flag_q;
  endproperty
  a_inside_miss: assert property (p_inside_miss) else $error("boundary code set flag");

  property p_outside;
    RESULT_I.done && !RESULT_I.diff && upper_q == 16'h0080 && lower_q == 16'h0040
      && RESULT_I.word == 16'h0081 |=> flag_q;
  endproperty
  a_outside: assert property (p_outside) else $error("outside result did not set flag");

  property p_unsigned;
    RESULT_I.done && !RESULT_I.diff && !flag_q && !SFR_REQ_I.we
      && upper_q == 16'hFFFF && lower_q == 16'h0040 && RESULT_I.word == 16'h0050 |=> !flag_q;
  endproperty
  a_unsigned: assert property (p_unsigned) else $error("single-ended compare not unsigned");

  property p_signed;
    RESULT_I.done && RESULT_I.diff && upper_q == 16'hFFFF && lower_q == 16'h0040
      && RESULT_I.word == 16'h0000 |=> flag_q;
  endproperty
  a_signed: assert property (p_signed) else $error("differential compare not signed");

  property p_hold;
    flag_q ##0 s_quiet [*3] |=> flag_q;
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without a clear");

  property p_clear;
    s_clear and !RESULT_I.done |=> !flag_q ##0 !WIN_FLAG_O;
  endproperty
  a_clear: assert property (p_clear) else $error("clear write did not clear flag");

  property p_set_wins;
    s_clear and (RESULT_I.done && match) |=> flag_q;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("match lost in clearing cycle");

  property p_no_done;
    !flag_q && !RESULT_I.done |=> !flag_q;
  endproperty
  a_no_done: assert property (p_no_done) else $error("flag set without a conversion");

  property p_result;
    RESULT_I.done ##1 (SFR_REQ_I.re && SFR_REQ_I.addr == ADDR_RES_LOW && !RESULT_I.done)
      |=> SFR_RDATA_O == $past(RESULT_I.word[7:0], 2);
  endproperty
  a_result: assert property (p_result) else $error("result low byte not captured");

  property p_limit;
    SFR_REQ_I.we && SFR_REQ_I.addr == ADDR_UPPER_HIGH |=> upper_q[15:8] == $past(SFR_REQ_I.wdata);
  endproperty
  a_limit: assert property (p_limit) else $error("upper limit high byte not written");

  property p_read_flag;
    SFR_REQ_I.re && SFR_REQ_I.addr == ADDR_CTRL |=> SFR_RDATA_O[CTRL_FLAG_BIT] == $past(flag_q);
  endproperty
  a_read_flag: assert property (p_read_flag) else $error("control read shows wrong flag");

  property p_mirror;
    WIN_FLAG_O == flag_q;
  endproperty
  a_mirror: assert property (p_mirror) else $error("request line differs from flag");

  property p_lower_limit;
    SFR_REQ_I.we && SFR_REQ_I.addr == ADDR_LOWER_LOW |=> lower_q[7:0] == $past(SFR_REQ_I.wdata);
  endproperty
  a_lower_limit: assert property (p_lower_limit) else $error("lower limit low byte not written");

  property p_capture;
    RESULT_I.done |=> result_q == $past(RESULT_I.word);
  endproperty
  a_capture: assert property (p_capture) else $error("result word not captured");

  property p_read_only;
    SFR_REQ_I.we && SFR_REQ_I.addr == ADDR_RES_HIGH && !RESULT_I.done |=> $stable(result_q);
  endproperty
  a_read_only: assert property (p_read_only) else $error("result register took a write");

endmodule

//--- verif/awd_tb.sv
// self-checking bench for the converter window detector
`timescale 1ns/100ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH %0t got %h expected %h", $time, got, exp); end end
module tb;
  import awd_pkg::*;
  typedef struct packed {
    logic [WW-1:0] up;
    logic [WW-1:0] lo;
    logic [WW-1:0] w;
    logic          d;
    logic          e;
  } awd_vec_t;
  logic          clock;
  logic          rstn;
  awd_sfr_req_t  req;
  awd_result_t   res;
  logic [DW-1:0] rdata;
  logic          flag;
  int            failures;
  int            compares;
  int            cycles = 0;
  // limits, word, differential, expected flag; boundaries are the hard cases
  awd_vec_t      vec [16] = '{
    '{16'h0040, 16'h0080, 16'h0040, 1'h0, 1'h0}, '{16'h0040, 16'h0080, 16'h0041, 1'h0, 1'h1},
    '{16'h0040, 16'h0080, 16'h007F, 1'h0, 1'h1}, '{16'h0040, 16'h0080, 16'h0080, 1'h0, 1'h0},
    '{16'h0080, 16'h0040, 16'h003F, 1'h0, 1'h1}, '{16'h0080, 16'h0040, 16'h0040, 1'h0, 1'h0},
    '{16'h0080, 16'h0040, 16'h0080, 1'h0, 1'h0}, '{16'h0080, 16'h0040, 16'h0081, 1'h0, 1'h1},
    '{16'h0040, 16'h0080, 16'h03FF, 1'h0, 1'h0}, '{16'h0080, 16'h0040, 16'h03FF, 1'h0, 1'h1},
    '{16'hFFFF, 16'h0040, 16'hFFFF, 1'h1, 1'h0}, '{16'hFFFF, 16'h0040, 16'h0000, 1'h1, 1'h1},
    '{16'hFFFF, 16'h0040, 16'h0040, 1'h1, 1'h0}, '{16'h0040, 16'hFFFF, 16'hFFFE, 1'h1, 1'h1},
    '{16'h0040, 16'hFFFF, 16'h0041, 1'h1, 1'h1}, '{16'h0040, 16'hFFFF, 16'h0000, 1'h1, 1'h0}};

  awd_top uut (.CLOCK_I(clock), .RSTN_I(rstn), .SFR_REQ_I(req), .RESULT_I(res),
               .SFR_RDATA_O(rdata), .WIN_FLAG_O(flag));

  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  task automatic stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      stop_test();
    end
  end

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, we: 1'h1, re: 1'h0};
    @(posedge clock);
    req <= '0;
  endtask

  task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge clock);
    req <= '{addr: a, wdata: 8'h00, we: 1'h0, re: 1'h1};
    @(posedge clock);
    req <= '0;
    #1;
    `CHK(rdata, e)
  endtask

  task automatic set_lim(input logic [WW-1:0] u, input logic [WW-1:0] l);
    wr(ADDR_UPPER_HIGH, u[15:8]);
    wr(ADDR_UPPER_LOW, u[7:0]);
    wr(ADDR_LOWER_HIGH, l[15:8]);
    wr(ADDR_LOWER_LOW, l[7:0]);
  endtask

  task automatic conv(input logic [WW-1:0] w, input logic d, input logic e);
    @(posedge clock);
    res <= '{done: 1'h1, diff: d, word: w};
    @(posedge clock);
    res.done <= 1'h0;
    #1;
    `CHK(flag, e)
  endtask

  initial begin
    rstn = 1'h0;
    req = '0;
    res = '0;
    failures = 0;
    compares = 0;
    repeat (3) @(posedge clock);
    rstn <= 1'h1;
    rd_chk(ADDR_CTRL, CTRL_RESET);
    rd_chk(ADDR_UPPER_HIGH, UPPER_RESET[15:8]);
    rd_chk(ADDR_LOWER_LOW, LOWER_RESET[7:0]);
    rd_chk(ADDR_RES_HIGH, RESULT_RESET[15:8]);
    rd_chk(8'h00, 8'h00);
    set_lim(16'h1234, 16'hABCD);
    rd_chk(ADDR_UPPER_HIGH, 8'h12);
    rd_chk(ADDR_UPPER_LOW, 8'h34);
    rd_chk(ADDR_LOWER_HIGH, 8'hAB);
    rd_chk(ADDR_LOWER_LOW, 8'hCD);
    $display("test registers done");
    set_lim(16'h0040, 16'h0080);
    conv(16'h0050, 1'h0, 1'h1);
    conv(16'h03FF, 1'h0, 1'h1);
    rd_chk(ADDR_CTRL, 8'h08);
    rd_chk(ADDR_RES_HIGH, 8'h03);
    rd_chk(ADDR_RES_LOW, 8'hFF);
    wr(ADDR_RES_HIGH, 8'h55);
    rd_chk(ADDR_RES_HIGH, 8'h03);
    wr(ADDR_CTRL, 8'hF7);
    rd_chk(ADDR_CTRL, 8'hF7);
    wr(ADDR_CTRL, 8'hFF);
    rd_chk(ADDR_CTRL, 8'hF7);
    wr(ADDR_CTRL, 8'h00);
    // clear write and match in one cycle: the set wins; the result is read the cycle after
    @(posedge clock);
    req <= '{addr: ADDR_CTRL, wdata: 8'h00, we: 1'h1, re: 1'h0};
    res <= '{done: 1'h1, diff: 1'h0, word: 16'h0055};
    @(posedge clock);
    req <= '{addr: ADDR_RES_LOW, wdata: 8'h00, we: 1'h0, re: 1'h1};
    res.done <= 1'h0;
    #1;
    `CHK(flag, 1'h1)
    @(posedge clock);
    req <= '0;
    #1;
    `CHK(rdata, 8'h55)
    wr(ADDR_CTRL, 8'h00);
    // a matching word without a completion pulse must not be compared
    @(posedge clock);
    res.word <= 16'h0060;
    repeat (12) @(posedge clock);
    #1;
    `CHK(flag, 1'h0)
    // unsigned compare: 0xFFFF is the top code, not minus one
    set_lim(16'hFFFF, 16'h0040);
    conv(16'h0050, 1'h0, 1'h0);
    $display("test sticky flag done");
    foreach (vec[i]) begin
      set_lim(vec[i].up, vec[i].lo);
      conv(vec[i].w, vec[i].d, vec[i].e);
      wr(ADDR_CTRL, 8'h00);
    end
    $display("test window table done");
    stop_test();
  end
endmodule
